// ---- rtl/uwb_pkg.sv ----
// Shared constants and types of the serial wake-on-break block
package uwb_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_DATA = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_BAUD = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_WAKE_EN = 0;
	localparam int CTRL_SYNC = 1;
	localparam int CTRL_ABD_EN = 2;
	localparam int CTRL_ABD_OVF = 3;
	localparam int STAT_RX_FLAG = 0;
	localparam int STAT_RX_IDLE = 1;
	localparam int STAT_FRAME = 2;
	localparam int STAT_ARMED = 3;
	localparam int STAT_BREAK = 4;
	localparam int IRQ_W = 6;
	localparam int IRQ_WAKE = 0;
	localparam int IRQ_BREAK_END = 1;
	localparam int IRQ_RX_CHAR = 2;
	localparam int IRQ_FRAME = 3;
	localparam int IRQ_OVERRUN = 4;
	localparam int IRQ_ABD_OVF = 5;

	// ------------------------------------------------------------
	// Widths, rates and reset values
	// ------------------------------------------------------------
	localparam int CHAR_W = 8;
	localparam int BIT_CNT_W = 4;
	localparam int BAUD_W = 16;
	localparam int ABD_CNT_W = 16;
	localparam int CLK_HZ = 125_000_000;
	localparam int BIT_RATE = 115_200;
	localparam logic [BAUD_W-1:0] BAUD_DIV_RST = BAUD_W'(CLK_HZ / BIT_RATE);
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;

	typedef enum logic [2:0] {
		uwb_wake_off = 3'h1,
		uwb_wake_armed = 3'h2,
		uwb_wake_break = 3'h4
	} uwb_wake_state_t;

	typedef enum logic [3:0] {
		uwb_rx_idle = 4'h1,
		uwb_rx_start = 4'h2,
		uwb_rx_data = 4'h4,
		uwb_rx_stop = 4'h8
	} uwb_rx_state_t;

endpackage : uwb_pkg

// ---- rtl/uwb_rx.sv ----
// Plain 8N1 character receiver, held idle while disabled
module uwb_rx (
	input wire logic clk,
	input wire logic reset_n,
	uwb_rx_if.rcv rx
);
	uwb_pkg::uwb_rx_state_t state_reg;
	logic prev_reg;
	logic [uwb_pkg::BAUD_W-1:0] tick_reg;
	logic [uwb_pkg::BIT_CNT_W-1:0] bit_reg;
	logic [uwb_pkg::CHAR_W-1:0] shift_reg;
	logic tick_done;

	assign tick_done = (tick_reg == '0);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= uwb_pkg::uwb_rx_idle;
			prev_reg <= 1'b1;
			tick_reg <= '0;
			bit_reg <= '0;
			shift_reg <= '0;
			rx.data <= '0;
			rx.valid <= 1'b0;
			rx.frame_err <= 1'b0;
		end else begin
			prev_reg <= rx.rx_line;
			rx.valid <= 1'b0;
			if (!tick_done) begin
				tick_reg <= tick_reg - 1'b1;
			end
			if (!rx.rx_enable) begin
				state_reg <= uwb_pkg::uwb_rx_idle;
			end else begin
				unique case (state_reg)
					uwb_pkg::uwb_rx_idle: begin
						// Any fall is a start bit, even mid-character after a wake
						if (prev_reg && !rx.rx_line) begin
							tick_reg <= rx.baud_div >> 1;
							state_reg <= uwb_pkg::uwb_rx_start;
						end
					end
					uwb_pkg::uwb_rx_start: begin
						if (tick_done) begin
							// Reload is one short: the zero cycle itself counts as a cycle
							tick_reg <= rx.baud_div - 1'b1;
							bit_reg <= '0;
							state_reg <= rx.rx_line ? uwb_pkg::uwb_rx_idle : uwb_pkg::uwb_rx_data;
						end
					end
					uwb_pkg::uwb_rx_data: begin
						if (tick_done) begin
							tick_reg <= rx.baud_div - 1'b1;
							shift_reg <= {rx.rx_line, shift_reg[uwb_pkg::CHAR_W-1:1]};
							bit_reg <= bit_reg + 1'b1;
							if (bit_reg == uwb_pkg::BIT_CNT_W'(uwb_pkg::CHAR_W - 1)) begin
								state_reg <= uwb_pkg::uwb_rx_stop;
							end
						end
					end
					uwb_pkg::uwb_rx_stop: begin
						if (tick_done) begin
							rx.data <= shift_reg;
							rx.frame_err <= !rx.rx_line;
							rx.valid <= 1'b1;
							state_reg <= uwb_pkg::uwb_rx_idle;
						end
					end
				endcase
			end
		end
	end

	assign rx.idle = (state_reg == uwb_pkg::uwb_rx_idle);
endmodule : uwb_rx

// ---- rtl/uwb_rx_if.sv ----
// Link between the wake controller and the character receiver
interface uwb_rx_if;
	logic rx_line;
	logic rx_enable;
	logic [uwb_pkg::BAUD_W-1:0] baud_div;
	logic [uwb_pkg::CHAR_W-1:0] data;
	logic valid;
	logic frame_err;
	logic idle;

	modport ctl (
		output rx_line,
		output rx_enable,
		output baud_div,
		input data,
		input valid,
		input frame_err,
		input idle
	);

	modport rcv (
		input rx_line,
		input rx_enable,
		input baud_div,
		output data,
		output valid,
		output frame_err,
		output idle
	);
endinterface : uwb_rx_if

// ---- rtl/uwb_sync.sv ----
// Two-stage synchroniser for a single level
module uwb_sync (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic d,
	output logic q
);
	logic meta_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= 1'b1;
			q <= 1'b1;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : uwb_sync

// ---- rtl/uwb_top.sv ----
// Serial port receive side with wake-on-break and Avalon-MM registers
//
// Behaviour
// - Wake detection only in asynchronous mode
// - Armed wake holds receiver idle
// - Falling receive line is the wake event
// - Wake sets receive flag immediately
// - Wake flagged with clock or clockless
// - Reading receive data clears receive flag
// - Break end rise clears wake enable
// - Then receiver idles, accepts next start
// - Nonzero character low time counts as wake
// - Rest of that character becomes fragment
// - Sleep stops port clocks; no reception
// - Overflow sticks while autobaud enable set
module uwb_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [uwb_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [uwb_pkg::DATA_W-1:0] avs_writedata,
	output logic [uwb_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serial_receive_line,
	input wire logic sleep_mode,
	output logic wake_request,
	output logic irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	uwb_rx_if rx_bus ();

	logic rx_sync;
	logic rx_prev_reg;
	logic rx_fall;
	logic latch_sync;
	logic latch_sync_n;
	logic latch_prev_reg;
	logic latch_rise;
	logic wake_latch_reg;
	logic wake_latch_clr_reg;
	logic wake_latch_clr_n;
	logic wake_arm_reg;

	uwb_pkg::uwb_wake_state_t wake_state_reg;
	uwb_pkg::uwb_wake_state_t wake_state_next;
	logic wake_event;
	logic break_end;

	logic wake_en_reg;
	logic sync_mode_reg;
	logic abd_en_reg;
	logic abd_ovf_reg;
	logic [uwb_pkg::ABD_CNT_W-1:0] abd_cnt_reg;
	logic abd_wrap;

	logic [uwb_pkg::BAUD_W-1:0] baud_div_reg;
	logic [uwb_pkg::CHAR_W-1:0] data_reg;
	logic rx_flag_reg;
	logic data_full_reg;
	logic frame_reg;

	logic [uwb_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [uwb_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [uwb_pkg::IRQ_W-1:0] irq_event;

	logic bus_req;
	logic bus_acc;
	logic wr_acc;
	logic rd_acc;
	logic [uwb_pkg::DATA_W-1:0] rd_next;

	// ------------------------------------------------------------
	// Receive line synchronisation and edges
	// ------------------------------------------------------------
	uwb_sync u_rx_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(serial_receive_line),
		.q(rx_sync)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_prev_reg <= 1'b1;
		end else begin
			rx_prev_reg <= rx_sync;
		end
	end

	assign rx_fall = rx_prev_reg && !rx_sync;

	// ------------------------------------------------------------
	// Clockless wake latch for sleep
	// ------------------------------------------------------------
	// Caught on the line edge itself, so it works with clk stopped
	always_ff @(negedge serial_receive_line or negedge wake_latch_clr_n) begin
		if (!wake_latch_clr_n) begin
			wake_latch_reg <= 1'b0;
		end else begin
			wake_latch_reg <= wake_arm_reg;
		end
	end

	// Clear is a registered level, so the derived reset has no glitch
	assign wake_latch_clr_n = reset_n && !wake_latch_clr_reg;

	uwb_sync u_latch_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(!wake_latch_reg),
		.q(latch_sync_n)
	);

	// Carried inverted so the synchroniser's reset level means no wake
	assign latch_sync = !latch_sync_n;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_prev_reg <= 1'b0;
			wake_latch_clr_reg <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			latch_prev_reg <= latch_sync;
			wake_latch_clr_reg <= latch_sync;
			// Clocked copy; the latch itself stays clockless
			wake_request <= latch_sync;
		end
	end

	assign latch_rise = latch_sync && !latch_prev_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_arm_reg <= 1'b0;
		end else begin
			wake_arm_reg <= (wake_state_next == uwb_pkg::uwb_wake_armed);
		end
	end

	// ------------------------------------------------------------
	// Wake state machine
	// ------------------------------------------------------------
	always_comb begin
		wake_state_next = wake_state_reg;
		wake_event = 1'b0;
		break_end = 1'b0;
		unique case (wake_state_reg)
			uwb_pkg::uwb_wake_off: begin
				if (wake_en_reg && !sync_mode_reg) begin
					wake_state_next = uwb_pkg::uwb_wake_armed;
				end
			end
			uwb_pkg::uwb_wake_armed: begin
				if (!wake_en_reg || sync_mode_reg) begin
					wake_state_next = uwb_pkg::uwb_wake_off;
				end else if (rx_fall || latch_rise) begin
					wake_event = 1'b1;
					wake_state_next = uwb_pkg::uwb_wake_break;
				end
			end
			uwb_pkg::uwb_wake_break: begin
				if (!wake_en_reg || sync_mode_reg) begin
					wake_state_next = uwb_pkg::uwb_wake_off;
				end else if (rx_sync) begin
					// Level test also ends a break that rose during sleep
					break_end = 1'b1;
					wake_state_next = uwb_pkg::uwb_wake_off;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_state_reg <= uwb_pkg::uwb_wake_off;
		end else begin
			wake_state_reg <= wake_state_next;
		end
	end

	// ------------------------------------------------------------
	// Receiver hookup
	// ------------------------------------------------------------
	assign rx_bus.rx_line = rx_sync;
	// Held idle while wake is armed or the port clocks are stopped
	assign rx_bus.rx_enable = !(wake_en_reg && !sync_mode_reg) && !sleep_mode;
	assign rx_bus.baud_div = baud_div_reg;

	uwb_rx u_rx (
		.clk(clk),
		.reset_n(reset_n),
		.rx(rx_bus.rcv)
	);

	// ------------------------------------------------------------
	// Avalon-MM slave handshake
	// ------------------------------------------------------------
	// Fixed one wait cycle: request seen, then answered next edge
	assign bus_req = avs_read || avs_write;
	assign bus_acc = bus_req && !avs_waitrequest;
	assign wr_acc = avs_write && !avs_waitrequest;
	assign rd_acc = avs_read && !avs_waitrequest;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(bus_req && avs_waitrequest);
		end
	end

	always_comb begin
		rd_next = '0;
		unique case (avs_address)
			uwb_pkg::OFF_CTRL: begin
				rd_next[uwb_pkg::CTRL_WAKE_EN] = wake_en_reg;
				rd_next[uwb_pkg::CTRL_SYNC] = sync_mode_reg;
				rd_next[uwb_pkg::CTRL_ABD_EN] = abd_en_reg;
				rd_next[uwb_pkg::CTRL_ABD_OVF] = abd_ovf_reg;
			end
			uwb_pkg::OFF_STAT: begin
				rd_next[uwb_pkg::STAT_RX_FLAG] = rx_flag_reg;
				rd_next[uwb_pkg::STAT_RX_IDLE] = rx_bus.idle;
				rd_next[uwb_pkg::STAT_FRAME] = frame_reg;
				rd_next[uwb_pkg::STAT_ARMED] = (wake_state_reg == uwb_pkg::uwb_wake_armed);
				rd_next[uwb_pkg::STAT_BREAK] = (wake_state_reg == uwb_pkg::uwb_wake_break);
			end
			uwb_pkg::OFF_IRQ_STAT: rd_next[uwb_pkg::IRQ_W-1:0] = irq_stat_reg;
			uwb_pkg::OFF_IRQ_MASK: rd_next[uwb_pkg::IRQ_W-1:0] = irq_mask_reg;
			uwb_pkg::OFF_DATA: rd_next[uwb_pkg::CHAR_W-1:0] = data_reg;
			uwb_pkg::OFF_BAUD: rd_next[uwb_pkg::BAUD_W-1:0] = baud_div_reg;
			default: rd_next = '0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= '0;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_next;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_en_reg <= 1'b0;
			sync_mode_reg <= 1'b0;
		end else begin
			if (wr_acc && avs_address == uwb_pkg::OFF_CTRL) begin
				wake_en_reg <= avs_writedata[uwb_pkg::CTRL_WAKE_EN];
				sync_mode_reg <= avs_writedata[uwb_pkg::CTRL_SYNC];
			end
			// Hardware clear wins so a rewrite cannot re-arm a finished break
			if (break_end) begin
				wake_en_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baud_div_reg <= uwb_pkg::BAUD_DIV_RST;
		end else if (wr_acc && avs_address == uwb_pkg::OFF_BAUD) begin
			baud_div_reg <= avs_writedata[uwb_pkg::BAUD_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Auto-baud timer and overflow
	// ------------------------------------------------------------
	assign abd_wrap = abd_en_reg && (abd_cnt_reg == '1);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			abd_cnt_reg <= '0;
		end else if (!abd_en_reg || rx_fall) begin
			abd_cnt_reg <= '0;
		end else begin
			abd_cnt_reg <= abd_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			abd_en_reg <= 1'b0;
			abd_ovf_reg <= 1'b0;
		end else begin
			if (wr_acc && avs_address == uwb_pkg::OFF_CTRL) begin
				abd_en_reg <= avs_writedata[uwb_pkg::CTRL_ABD_EN];
				// Clear only takes once enable is already low
				if (!abd_en_reg) begin
					abd_ovf_reg <= avs_writedata[uwb_pkg::CTRL_ABD_OVF];
				end
			end
			if (abd_wrap) begin
				abd_ovf_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Receive data and receive flag
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_reg <= '0;
			frame_reg <= 1'b0;
		end else if (rx_bus.valid) begin
			// A fragment after a nonzero wake lands here too
			data_reg <= rx_bus.data;
			frame_reg <= rx_bus.frame_err;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_flag_reg <= 1'b0;
			data_full_reg <= 1'b0;
		end else begin
			if (rd_acc && avs_address == uwb_pkg::OFF_DATA) begin
				rx_flag_reg <= 1'b0;
				data_full_reg <= 1'b0;
			end
			// Set after clear: an event in the read cycle is kept
			if (wake_event) begin
				rx_flag_reg <= 1'b1;
			end
			if (rx_bus.valid) begin
				rx_flag_reg <= 1'b1;
				data_full_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, mask and output
	// ------------------------------------------------------------
	always_comb begin
		irq_event = '0;
		irq_event[uwb_pkg::IRQ_WAKE] = wake_event;
		irq_event[uwb_pkg::IRQ_BREAK_END] = break_end;
		irq_event[uwb_pkg::IRQ_RX_CHAR] = rx_bus.valid;
		irq_event[uwb_pkg::IRQ_FRAME] = rx_bus.valid && rx_bus.frame_err;
		irq_event[uwb_pkg::IRQ_OVERRUN] = rx_bus.valid && data_full_reg
			&& !(rd_acc && avs_address == uwb_pkg::OFF_DATA);
		irq_event[uwb_pkg::IRQ_ABD_OVF] = abd_wrap && !abd_ovf_reg;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_reg <= '0;
		end else if (wr_acc && avs_address == uwb_pkg::OFF_IRQ_STAT) begin
			irq_stat_reg <= (irq_stat_reg & ~avs_writedata[uwb_pkg::IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_event;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_reg <= uwb_pkg::IRQ_MASK_RST;
		end else if (wr_acc && avs_address == uwb_pkg::OFF_IRQ_MASK) begin
			irq_mask_reg <= avs_writedata[uwb_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

endmodule : uwb_top

// ---- verif/uwb_monitor.sv ----
// Port checker for the wake-on-break block
module uwb_monitor (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [uwb_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [uwb_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [uwb_pkg::DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic serial_receive_line,
	input wire logic sleep_mode,
	input wire logic wake_request,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [uwb_pkg::IRQ_W-1:0] mask_q;
	logic line_q;
	logic [7:0] fall_age;
	logic req;
	logic mapped;

	assign req = avs_read || avs_write;
	assign mapped = avs_address inside {uwb_pkg::OFF_CTRL, uwb_pkg::OFF_STAT, uwb_pkg::OFF_IRQ_STAT,
		uwb_pkg::OFF_IRQ_MASK, uwb_pkg::OFF_DATA, uwb_pkg::OFF_BAUD};

	// Mask shadow, taken at the edge where the write completes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_q <= '0;
		end else if (avs_write && !avs_waitrequest && avs_address == uwb_pkg::OFF_IRQ_MASK) begin
			mask_q <= avs_writedata[uwb_pkg::IRQ_W-1:0];
		end
	end

	// Cycles since the line was last seen falling, saturating
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			line_q <= 1'b1;
			fall_age <= 8'hFF;
		end else begin
			line_q <= serial_receive_line;
			if (line_q && !serial_receive_line) begin
				fall_age <= 8'h00;
			end else if (fall_age != 8'hFF) begin
				fall_age <= fall_age + 8'h01;
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_wait_after_req: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not lowered after request");
	a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_wait_idle_high: assert property (!req && avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest dropped without request");
	a_unmapped_reads_zero: assert property (avs_read && avs_waitrequest && !mapped |=> avs_readdata == '0)
		else $error("unmapped read not zero");
	a_upper_bits_zero: assert property (avs_read && avs_waitrequest |=> avs_readdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_readdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data changed without read");
	a_irq_masked_off: assert property (mask_q == '0 && $past(mask_q) == '0 |-> !irq)
		else $error("irq high with all sources masked");
	a_irq_rise_mask: assert property ($rose(irq) |-> $past(mask_q) != '0)
		else $error("irq rose while mask was zero");
	a_wake_after_fall: assert property ($rose(wake_request) |-> fall_age <= 8'h04)
		else $error("wake request not tied to a recent line fall");
endmodule : uwb_monitor

bind uwb_top uwb_monitor u_mon (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .serial_receive_line(serial_receive_line),
	.sleep_mode(sleep_mode), .wake_request(wake_request), .irq(irq));

// ---- verif/uwb_peer_model.sv ----
// Remote serial transmitter driving the receive line
module uwb_peer_model #(
	parameter int BIT_CYC = 16
) (
	input wire logic clk,
	output logic line
);
	timeunit 1ns;
	timeprecision 1ps;

	initial line = 1'b1;

	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge clk);
	endtask : hold

	// ------------------------------------------------------------
	// Frames
	// ------------------------------------------------------------
	// Stop level selectable so a framing fault can be injected
	task automatic send_char(input logic [7:0] d, input logic stop);
		hold(1'b0, BIT_CYC);
		for (int i = 0; i < 8; i++) begin
			hold(d[i], BIT_CYC);
		end
		hold(stop, BIT_CYC);
		hold(1'b1, 2 * BIT_CYC);
	endtask : send_char

	// All-zero wake character, then idle long enough to start up
	task automatic send_break(input int nbits);
		hold(1'b0, nbits * BIT_CYC);
		hold(1'b1, 4 * BIT_CYC);
	endtask : send_break
endmodule : uwb_peer_model

// ---- verif/uwb_top_tb_top.sv ----
// Register-level testbench of the wake-on-break block
module uwb_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_CYC = 16;
	logic clk;
	logic reset_n;
	logic [uwb_pkg::ADDR_W-1:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [uwb_pkg::DATA_W-1:0] avs_writedata;
	logic [uwb_pkg::DATA_W-1:0] avs_readdata;
	logic avs_waitrequest;
	logic serial_receive_line;
	logic sleep_mode;
	logic wake_request;
	logic irq;
	int fail_count;
	int tests_run;

	uwb_top u_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_receive_line(serial_receive_line),
		.sleep_mode(sleep_mode), .wake_request(wake_request), .irq(irq));
	uwb_peer_model #(.BIT_CYC(BIT_CYC)) u_peer (.clk(clk), .line(serial_receive_line));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// ------------------------------------------------------------
	// Bus access: hold the request until waitrequest is seen low
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		logic late;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		late = (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
		if (late) begin
			fail_count++;
			final_report();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask : rdm

	task automatic poll(input logic [7:0] a, input int b, input int lim);
		logic [31:0] q;
		int n;
		q = '0;
		for (n = 0; n < lim && q[b] !== 1'b1; n++) begin
			bus(1'b0, a, 32'h0, q);
		end
		if (q[b] !== 1'b1) begin
			fail_count++;
			final_report();
		end
	endtask : poll

	// Waits for wake_request when w is set, otherwise for irq
	task automatic wait_out(input logic w);
		int n;
		for (n = 0; n < 200 && (w ? wake_request : irq) !== 1'b1; n++) begin
			@(posedge clk);
		end
		if ((w ? wake_request : irq) !== 1'b1) begin
			fail_count++;
			final_report();
		end
	endtask : wait_out

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q;
		reset_n = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		sleep_mode = 1'b0;
		fail_count = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rdm(uwb_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rdm(uwb_pkg::OFF_STAT, 32'hFFFFFFFF, 32'h2);
		rdm(uwb_pkg::OFF_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
		rdm(uwb_pkg::OFF_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		rdm(uwb_pkg::OFF_BAUD, 32'hFFFFFFFF, 32'h43D);
		wr(8'h18, 32'hFFFF);
		rdm(8'h18, 32'hFFFFFFFF, 32'h0);
		$display("test reset done");
		wr(uwb_pkg::OFF_BAUD, BIT_CYC);
		u_peer.send_char(8'hA5, 1'b1);
		poll(uwb_pkg::OFF_IRQ_STAT, uwb_pkg::IRQ_RX_CHAR, 50);
		rdm(uwb_pkg::OFF_DATA, 32'hFF, 32'hA5);
		wr(uwb_pkg::OFF_IRQ_STAT, 32'h3F);
		$display("test char done");
		wr(uwb_pkg::OFF_IRQ_MASK, 32'h3);
		rdm(uwb_pkg::OFF_STAT, 32'h2, 32'h2);
		wr(uwb_pkg::OFF_CTRL, 32'h1);
		rdm(uwb_pkg::OFF_STAT, 32'h8, 32'h8);
		fork
			u_peer.send_break(13);
			begin
				wait_out(1'b0);
				rdm(uwb_pkg::OFF_IRQ_STAT, 32'h3, 32'h1);
				rdm(uwb_pkg::OFF_STAT, 32'h11, 32'h11);
				rdm(uwb_pkg::OFF_CTRL, 32'h1, 32'h1);
			end
		join
		rdm(uwb_pkg::OFF_CTRL, 32'h1, 32'h0);
		rdm(uwb_pkg::OFF_IRQ_STAT, 32'h3, 32'h3);
		rdm(uwb_pkg::OFF_DATA, 32'hFF, 32'hA5);
		rdm(uwb_pkg::OFF_STAT, 32'h1, 32'h0);
		wr(uwb_pkg::OFF_IRQ_STAT, 32'h3F);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		u_peer.send_char(8'h3C, 1'b1);
		poll(uwb_pkg::OFF_IRQ_STAT, uwb_pkg::IRQ_RX_CHAR, 50);
		rdm(uwb_pkg::OFF_DATA, 32'hFF, 32'h3C);
		wr(uwb_pkg::OFF_IRQ_STAT, 32'h3F);
		$display("test wake done");
		wr(uwb_pkg::OFF_CTRL, 32'h1);
		u_peer.send_char(8'h55, 1'b1);
		poll(uwb_pkg::OFF_IRQ_STAT, uwb_pkg::IRQ_RX_CHAR, 50);
		rdm(uwb_pkg::OFF_IRQ_STAT, 32'h1F, 32'h7);
		rdm(uwb_pkg::OFF_DATA, 32'hFF, 32'hD5);
		wr(uwb_pkg::OFF_IRQ_STAT, 32'h3F);
		$display("test fragment done");
		u_peer.send_char(8'h81, 1'b0);
		poll(uwb_pkg::OFF_IRQ_STAT, uwb_pkg::IRQ_FRAME, 50);
		rdm(uwb_pkg::OFF_STAT, 32'h4, 32'h4);
		u_peer.send_char(8'h42, 1'b1);
		poll(uwb_pkg::OFF_IRQ_STAT, uwb_pkg::IRQ_OVERRUN, 50);
		bus(1'b0, uwb_pkg::OFF_DATA, 32'h0, q);
		wr(uwb_pkg::OFF_IRQ_STAT, 32'h3F);
		$display("test errors done");
		wr(uwb_pkg::OFF_CTRL, 32'h3);
		u_peer.send_break(13);
		rdm(uwb_pkg::OFF_IRQ_STAT, 32'h1, 32'h0);
		wr(uwb_pkg::OFF_CTRL, 32'h0);
		bus(1'b0, uwb_pkg::OFF_DATA, 32'h0, q);
		wr(uwb_pkg::OFF_IRQ_STAT, 32'h3F);
		$display("test sync done");
		sleep_mode <= 1'b1;
		u_peer.send_char(8'h99, 1'b1);
		rdm(uwb_pkg::OFF_IRQ_STAT, 32'h4, 32'h0);
		wr(uwb_pkg::OFF_CTRL, 32'h1);
		// Let the arm flop settle before the line falls
		@(posedge clk);
		fork
			u_peer.send_break(13);
			wait_out(1'b1);
		join
		sleep_mode <= 1'b0;
		rdm(uwb_pkg::OFF_IRQ_STAT, 32'h3, 32'h3);
		rdm(uwb_pkg::OFF_CTRL, 32'h1, 32'h0);
		bus(1'b0, uwb_pkg::OFF_DATA, 32'h0, q);
		wr(uwb_pkg::OFF_IRQ_STAT, 32'h3F);
		$display("test sleep done");
		wr(uwb_pkg::OFF_CTRL, 32'h4);
		poll(uwb_pkg::OFF_IRQ_STAT, uwb_pkg::IRQ_ABD_OVF, 30000);
		wr(uwb_pkg::OFF_CTRL, 32'h4);
		rdm(uwb_pkg::OFF_CTRL, 32'hC, 32'hC);
		wr(uwb_pkg::OFF_CTRL, 32'h0);
		rdm(uwb_pkg::OFF_CTRL, 32'hC, 32'h8);
		wr(uwb_pkg::OFF_CTRL, 32'h0);
		rdm(uwb_pkg::OFF_CTRL, 32'hC, 32'h0);
		$display("test autobaud done");
		final_report();
	end
endmodule : uwb_top_tb_top
